// File: design/homing_if.sv
// Interface: synchronised input events passed to the sequencer
`timescale 1ns/1ns
interface homing_if;
   logic origin_lvl;
   logic origin_rise;
   logic origin_fall;
   logic rev_limit;
   logic index_rise;

   modport src (output origin_lvl, output origin_rise,
                output origin_fall, output rev_limit,
                output index_rise);
   modport dst (input origin_lvl, input origin_rise,
                input origin_fall, input rev_limit,
                input index_rise);
endinterface : homing_if

// File: design/homing_input_sync.sv
// Input synchroniser for switch and index pins, with edge detectors on the origin and index pins
`timescale 1ns/1ns
module homing_input_sync
   import homing_pkg::*;
(
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst,
   // Raw pins
   input  wire logic i_origin,
   input  wire logic i_rev_limit,
   input  wire logic i_index,
   // Events
   homing_if.src     ev
);
   logic [1:0] org_q, org_d;
   logic [1:0] lim_q, lim_d;
   logic [1:0] idx_q, idx_d;
   logic       org_prev_q, org_prev_d;
   logic       idx_prev_q, idx_prev_d;

   // ==========================================================
   // Two-stage capture; only stage 2 feeds edge logic
   always_comb begin
      org_d      = {org_q[0], i_origin};
      lim_d      = {lim_q[0], i_rev_limit};
      idx_d      = {idx_q[0], i_index};
      org_prev_d = org_q[1];
      idx_prev_d = idx_q[1];
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         org_q      <= SYNC_RESET;
         lim_q      <= SYNC_RESET;
         idx_q      <= SYNC_RESET;
         org_prev_q <= 1'b0;
         idx_prev_q <= 1'b0;
      end else begin
         org_q      <= org_d;
         lim_q      <= lim_d;
         idx_q      <= idx_d;
         org_prev_q <= org_prev_d;
         idx_prev_q <= idx_prev_d;
      end
   end

   // ==========================================================
   // Level and edge outputs
   assign ev.origin_lvl  = org_q[1];
   assign ev.origin_rise = org_q[1] & ~org_prev_q;
   assign ev.origin_fall = ~org_q[1] & org_prev_q;
   assign ev.rev_limit   = lim_q[1];
   assign ev.index_rise  = idx_q[1] & ~idx_prev_q;

endmodule : homing_input_sync

// File: design/homing_pkg.sv
// Package: constants and types for the origin-switch homing sequencer
package homing_pkg;

   // ==========================================================
   // Method selection
   localparam logic METHOD_11_3 = 1'b0;
   localparam logic METHOD_12_1 = 1'b1;

   // ==========================================================
   // Command encoding
   localparam logic DIR_FWD   = 1'b1;
   localparam logic DIR_REV   = 1'b0;
   localparam logic SPEED_HI  = 1'b1;
   localparam logic SPEED_LO  = 1'b0;

   // ==========================================================
   // Reset values
   localparam logic [1:0] SYNC_RESET = 2'h0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_REV_HI,
      ST_FWD_HI,
      ST_FWD_LO,
      ST_REV_LO,
      ST_WAIT_Z,
      ST_DONE
   } home_state_e;

endpackage : homing_pkg

// File: design/homing_sequence_origin_switch.sv
// Homing sequencer for origin-switch methods 11.3 and 12.1
`timescale 1ns/1ns
module homing_sequence_origin_switch
   import homing_pkg::*;
(
   // Clock and reset
   input  wire logic i_clock,
   input  wire logic i_rst,
   // Control
   input  wire logic i_start,
   input  wire logic i_method,
   // Sensor pins
   input  wire logic i_origin,
   input  wire logic i_rev_limit,
   input  wire logic i_index,
   // Motion command
   output logic      o_run,
   output logic      o_dir_fwd,
   output logic      o_speed_hi,
   output logic      o_busy,
   output logic      o_done
);
   homing_if ev ();

   homing_input_sync u_sync (
      .i_clock     (i_clock),
      .i_rst       (i_rst),
      .i_origin    (i_origin),
      .i_rev_limit (i_rev_limit),
      .i_index     (i_index),
      .ev          (ev)
   );

   home_state_e state_q, state_d;
   logic        method_q, method_d;
   logic        run_q, run_d;
   logic        dir_q, dir_d;
   logic        spd_q, spd_d;
   logic        busy_q, busy_d;
   logic        done_q, done_d;

   // ==========================================================
   // Sequencer
   always_comb begin
      state_d  = state_q;
      method_d = method_q;
      unique case (state_q)
         ST_IDLE, ST_DONE: begin
            if (i_start) begin
               method_d = i_method;
               state_d  = ST_REV_HI;
            end
         end
         ST_REV_HI: begin
            if (ev.origin_rise) begin
               state_d = ST_FWD_LO;
            end else if (method_q == METHOD_11_3 && ev.rev_limit) begin
               state_d = ST_FWD_HI;
            end
         end
         ST_FWD_HI: begin
            if (ev.origin_rise) begin
               state_d = ST_FWD_LO;
            end
         end
         ST_FWD_LO: begin
            if (ev.origin_fall) begin
               if (method_q == METHOD_11_3) begin
                  state_d = ST_WAIT_Z;
               end else begin
                  state_d = ST_REV_LO;
               end
            end
         end
         ST_REV_LO: begin
            if (ev.origin_rise) begin
               state_d = ST_WAIT_Z;
            end
         end
         ST_WAIT_Z: begin
            if (ev.index_rise) begin
               state_d = ST_DONE;
            end
         end
      endcase
   end

   // ==========================================================
   // Command decode; the last low-speed leg keeps moving while waiting
   always_comb begin
      run_d  = 1'b0;
      dir_d  = DIR_REV;
      spd_d  = SPEED_LO;
      busy_d = 1'b1;
      done_d = 1'b0;
      unique case (state_d)
         ST_IDLE: begin
            busy_d = 1'b0;
         end
         ST_DONE: begin
            busy_d = 1'b0;
            done_d = 1'b1;
         end
         ST_REV_HI: begin
            run_d = 1'b1;
            spd_d = SPEED_HI;
         end
         ST_FWD_HI: begin
            run_d = 1'b1;
            dir_d = DIR_FWD;
            spd_d = SPEED_HI;
         end
         ST_FWD_LO: begin
            run_d = 1'b1;
            dir_d = DIR_FWD;
         end
         ST_REV_LO: begin
            run_d = 1'b1;
         end
         ST_WAIT_Z: begin
            run_d = 1'b1;
            dir_d = (method_d == METHOD_11_3) ? DIR_FWD : DIR_REV;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_q  <= ST_IDLE;
         method_q <= METHOD_11_3;
         run_q    <= 1'b0;
         dir_q    <= DIR_REV;
         spd_q    <= SPEED_LO;
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
      end else begin
         state_q  <= state_d;
         method_q <= method_d;
         run_q    <= run_d;
         dir_q    <= dir_d;
         spd_q    <= spd_d;
         busy_q   <= busy_d;
         done_q   <= done_d;
      end
   end

   assign o_run      = run_q;
   assign o_dir_fwd  = dir_q;
   assign o_speed_hi = spd_q;
   assign o_busy     = busy_q;
   assign o_done     = done_q;

   // ==========================================================
   // Checks
   property p_start_rev_hi;
      @(posedge i_clock) disable iff (i_rst)
      (!busy_q && i_start) |=> (run_q && !dir_q && spd_q);
   endproperty
   a_start_rev_hi: assert property (p_start_rev_hi)
      else $error("start did not give reverse high speed");

   property p_start_12;
      @(posedge i_clock) disable iff (i_rst)
      (!busy_q && i_start && i_method) |=> (state_q == ST_REV_HI);
   endproperty
   a_start_12: assert property (p_start_12)
      else $error("method 12 did not start reverse high");

   property p_limit_turn;
      @(posedge i_clock) disable iff (i_rst)
      (state_q == ST_REV_HI && method_q == METHOD_11_3 && ev.rev_limit
       && !ev.origin_rise) |=> (dir_q && spd_q);
   endproperty
   a_limit_turn: assert property (p_limit_turn)
      else $error("reverse limit did not turn to forward high");

   property p_rise_fwd_lo;
      @(posedge i_clock) disable iff (i_rst)
      ((state_q == ST_REV_HI || state_q == ST_FWD_HI) && ev.origin_rise)
      |=> (run_q && dir_q && !spd_q);
   endproperty
   a_rise_fwd_lo: assert property (p_rise_fwd_lo)
      else $error("origin rise did not give forward low");

   property p_rise_12;
      @(posedge i_clock) disable iff (i_rst)
      (state_q == ST_REV_HI && method_q == METHOD_12_1 && ev.origin_rise)
      |=> (state_q == ST_FWD_LO);
   endproperty
   a_rise_12: assert property (p_rise_12)
      else $error("method 12 origin rise missed");

   property p_fall_rev_lo;
      @(posedge i_clock) disable iff (i_rst)
      (state_q == ST_FWD_LO && method_q == METHOD_12_1 && ev.origin_fall)
      |=> (run_q && !dir_q && !spd_q);
   endproperty
   a_fall_rev_lo: assert property (p_fall_rev_lo)
      else $error("origin fall did not give reverse low");

   property p_stop_11;
      @(posedge i_clock) disable iff (i_rst)
      (state_q == ST_WAIT_Z && method_q == METHOD_11_3 && ev.index_rise)
      |=> (!run_q && done_q);
   endproperty
   a_stop_11: assert property (p_stop_11)
      else $error("method 11 did not stop on index");

   property p_stop_12;
      @(posedge i_clock) disable iff (i_rst)
      (state_q == ST_WAIT_Z && method_q == METHOD_12_1 && ev.index_rise)
      |=> (!run_q && done_q && !busy_q);
   endproperty
   a_stop_12: assert property (p_stop_12)
      else $error("method 12 did not stop on index");

   property p_no_early_index;
      @(posedge i_clock) disable iff (i_rst)
      (state_q == ST_FWD_LO && ev.index_rise && !ev.origin_fall)
      |=> (run_q && !done_q);
   endproperty
   a_no_early_index: assert property (p_no_early_index)
      else $error("index accepted before origin edge");

   c_done_11: cover property (@(posedge i_clock) disable iff (i_rst)
      (method_q == METHOD_11_3 && done_q));
   c_done_12: cover property (@(posedge i_clock) disable iff (i_rst)
      (method_q == METHOD_12_1 && done_q));
   c_limit: cover property (@(posedge i_clock) disable iff (i_rst)
      (state_q == ST_FWD_HI));

endmodule : homing_sequence_origin_switch

// File: sim/sensor_model.sv
// Model of the origin switch, reverse limit switch and encoder index
`timescale 1ns/1ns
module sensor_model (
   // Clock
   input  wire logic i_clock,
   // Sensor pins
   output logic      o_origin,
   output logic      o_rev_limit,
   output logic      o_index
);
   // ==========================================================
   // Pin levels, all released at time zero
   initial begin
      o_origin    <= 1'b0;
      o_rev_limit <= 1'b0;
      o_index     <= 1'b0;
   end

   // ==========================================================
   // Pin actions, each entered just after a rising edge
   task automatic set_origin(input logic v);
      o_origin <= v;
      @(posedge i_clock);
   endtask : set_origin

   // Limit stays closed a while, as a real cam would under motion
   task automatic pulse_limit(input int width);
      o_rev_limit <= 1'b1;
      repeat (width) @(posedge i_clock);
      o_rev_limit <= 1'b0;
      @(posedge i_clock);
   endtask : pulse_limit

   // Width varies so slow motors with wide index marks are covered
   task automatic pulse_index(input int width);
      o_index <= 1'b1;
      repeat (width) @(posedge i_clock);
      o_index <= 1'b0;
      @(posedge i_clock);
   endtask : pulse_index
endmodule : sensor_model

// File: sim/tb_top.sv
// Testbench for the origin-switch homing sequencer
`timescale 1ns/1ns
module tb_top;
   import homing_pkg::*;
   // ==========================================================
   // Signals
   logic      i_clock;
   logic      i_rst;
   logic      i_start;
   logic      i_method;
   wire logic origin;
   wire logic rev_limit;
   wire logic index;
   logic      o_run;
   logic      o_dir_fwd;
   logic      o_speed_hi;
   logic      o_busy;
   logic      o_done;
   int        err_count;
   int        compares;
   int        cycles;

   // Expected {run, dir, speed, busy, done}
   localparam logic [4:0] REV_HI = {1'b1, DIR_REV, SPEED_HI, 2'b10};
   localparam logic [4:0] FWD_HI = {1'b1, DIR_FWD, SPEED_HI, 2'b10};
   localparam logic [4:0] FWD_LO = {1'b1, DIR_FWD, SPEED_LO, 2'b10};
   localparam logic [4:0] REV_LO = {1'b1, DIR_REV, SPEED_LO, 2'b10};
   localparam logic [4:0] DONE   = {1'b0, DIR_REV, SPEED_LO, 2'b01};

   // ==========================================================
   // Instances
   homing_sequence_origin_switch dut_u (
      .i_clock    (i_clock),
      .i_rst      (i_rst),
      .i_start    (i_start),
      .i_method   (i_method),
      .i_origin   (origin),
      .i_rev_limit(rev_limit),
      .i_index    (index),
      .o_run      (o_run),
      .o_dir_fwd  (o_dir_fwd),
      .o_speed_hi (o_speed_hi),
      .o_busy     (o_busy),
      .o_done     (o_done)
   );

   sensor_model model_u (
      .i_clock    (i_clock),
      .o_origin   (origin),
      .o_rev_limit(rev_limit),
      .o_index    (index)
   );

   // ==========================================================
   // Clock and timeout
   initial begin
      i_clock = 1'b0;
      forever #10 i_clock = ~i_clock;
   end

   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         $display("mismatch at %0t: run did not finish", $time);
         tally_and_finish();
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic tally_and_finish();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : tally_and_finish

   // Settle margin covers the 3-cycle pin-to-command delay
   task automatic settle();
      repeat (6) @(posedge i_clock);
   endtask : settle

   // Sampled mid-cycle so the edge's updates have landed
   task automatic chk(input logic [4:0] exp, input string what);
      logic [4:0] got;
      @(negedge i_clock);
      got = {o_run, o_dir_fwd, o_speed_hi, o_busy, o_done};
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch at %0t: %s got %b exp %b", $time, what, got,
                  exp);
      end
      @(posedge i_clock);
   endtask : chk

   task automatic start(input logic m);
      i_start  <= 1'b1;
      i_method <= m;
      @(posedge i_clock);
      i_start <= 1'b0;
      settle();
   endtask : start

   // ==========================================================
   // Scenarios
   task automatic t_reset();
      chk(5'h00, "reset outputs");
      $display("test reset done");
   endtask : t_reset

   task automatic t_m113();
      start(METHOD_11_3);
      chk(REV_HI, "11.3 start");
      model_u.pulse_index(2);
      settle();
      chk(REV_HI, "index before origin");
      model_u.pulse_limit(4);
      settle();
      chk(FWD_HI, "limit reverses");
      model_u.set_origin(1'b1);
      settle();
      chk(FWD_LO, "origin rise");
      model_u.pulse_index(2);
      settle();
      chk(FWD_LO, "index while on switch");
      model_u.set_origin(1'b0);
      settle();
      chk(FWD_LO, "origin fall keeps moving");
      model_u.pulse_index(5);
      settle();
      chk(DONE, "index stops");
      $display("test m113 done");
   endtask : t_m113

   task automatic t_m121();
      start(METHOD_12_1);
      chk(REV_HI, "12.1 start");
      start(METHOD_11_3);
      chk(REV_HI, "start while busy");
      model_u.pulse_limit(4);
      settle();
      chk(REV_HI, "limit ignored");
      model_u.set_origin(1'b1);
      settle();
      chk(FWD_LO, "origin rise");
      model_u.set_origin(1'b0);
      settle();
      chk(REV_LO, "origin fall");
      model_u.pulse_index(2);
      settle();
      chk(REV_LO, "index before re-rise");
      model_u.set_origin(1'b1);
      settle();
      chk(REV_LO, "re-rise keeps moving");
      model_u.pulse_index(2);
      settle();
      chk(DONE, "index stops");
      model_u.set_origin(1'b0);
      $display("test m121 done");
   endtask : t_m121

   // Origin met on the first leg, then a reset drops the command mid-run
   task automatic t_direct_reset();
      start(METHOD_11_3);
      model_u.set_origin(1'b1);
      settle();
      chk(FWD_LO, "11.3 direct origin rise");
      i_rst <= 1'b1;
      @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      chk(5'h00, "reset mid-run");
      model_u.set_origin(1'b0);
      settle();
      chk(5'h00, "idle ignores origin");
      $display("test direct reset done");
   endtask : t_direct_reset

   // ==========================================================
   // Main sequence
   initial begin
      i_rst     <= 1'b1;
      i_start   <= 1'b0;
      i_method  <= METHOD_11_3;
      err_count = 0;
      compares  = 0;
      cycles    = 0;
      repeat (6) @(posedge i_clock);
      i_rst <= 1'b0;
      @(posedge i_clock);
      t_reset();
      t_m113();
      t_m121();
      t_direct_reset();
      tally_and_finish();
   end
endmodule : tb_top
